// *** dv/cpd_mem_model.sv ***
`timescale 1ns/1ps

// Dot memory behind the selects; every selected sheet reads as PAT.
module cpd_mem_model
    import cpd_pkg::*;
#(
    parameter logic [6:0] PAT = 7'h2c
) (
    input wire logic clk,
    input wire logic [15:0] col_sel,
    input wire logic [7:0] row_sel,
    output logic [6:0] dot_data
);
    // Unselected lines show the inverse, so stale data never looks valid.
    // Read on pulse.
    always_ff @(posedge clk) begin
        dot_data <= ((|col_sel) && (|row_sel)) ? PAT : ~PAT;
    end
endmodule : cpd_mem_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps

// Bench for the position counter and dot readout of one character.
module tb_top;
    import cpd_pkg::*;

    // Short counts keep one character near 77k cycles.
    localparam int DLY = 50;
    localparam int FRM = 2400;
    localparam int HH = 2200;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic avail = 1'b0;
    logic [6:0] code = 7'h55;
    logic cr = 1'b0;
    logic [6:0] dots;
    logic [4:0] grp;
    logic lr, pbl, pbl_n, rhs, rhs_a, memory_read_level, jd;
    logic pbm, pbm_n, pbh, pbh_n;
    logic [15:0] dsel;
    logic np = 1'b0;
    logic pab = 1'b0;
    logic [15:0] col;
    logic [7:0] rsel;
    logic [3:0] vb;
    logic [2:0] hb;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    cpd_char_gen #(.DELAY_CYCLES(DLY), .FRAME_CYCLES(FRM),
        .HHOLD_CYCLES(HH)) dut_u (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CHAR_AVAIL(avail),
        .CHAR_CODE(code), .NONPRINT(np), .HTAB(1'b0), .CR_REQ(cr),
        .PAPER_ADV_BTN(pab), .DOT_DATA(dots), .GROUP_SEL(grp),
        .LR_SEL(lr), .POS_BIT_LOW(pbl), .POS_BIT_LOW_N(pbl_n),
        .POS_BIT_MID(pbm), .POS_BIT_MID_N(pbm_n), .POS_BIT_HIGH(pbh),
        .POS_BIT_HIGH_N(pbh_n), .ROW_HALF_SELECT(rhs),
        .ROW_HALF_SELECT_ALT(rhs_a), .MEMORY_READ_LEVEL(memory_read_level),
        .COL_SEL(col), .ROW_SEL(rsel), .DOT_SEL(dsel), .VERT_BIT_W1(vb[0]),
        .VERT_BIT_W2(vb[1]), .VERT_BIT_W4(vb[2]), .VERT_BIT_W8(vb[3]),
        .HORIZ_BIT_W1(hb[0]), .HORIZ_BIT_W2(hb[1]), .HORIZ_BIT_W4(hb[2]),
        .JET_DOWN(jd)
    );

    cpd_mem_model mem_u (
        .clk(clk), .col_sel(col), .row_sel(rsel), .dot_data(dots)
    );

    // Prints the counts and the verdict, then stops the run.
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Case equality, so an unknown never counts as a match.
    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Moves n edges and samples once the edge's updates have landed.
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // Bounded wait: 0 pulse high, 1 pulse low, 2 print over.
    task wt(input int k);
        int i;
        for (i = 0; i < 80000; i++) begin
            if ((k == 0 && memory_read_level === 1'b1) || (k == 1 && memory_read_level === 1'b0) ||
                (k == 2 && rsel === 8'h00)) break;
            settle(1);
        end
        if (i == 80000) begin
            n_errors++;
            test_done();
        end
    endtask : wt

    // One APB transfer; request held until PREADY is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reset state, control reset value and an unmapped read.
    task t_reset;
        settle(1);
        chk("group idle", grp, 5'h00);
        chk("lr home", lr, 1'b1);
        chk("jd idle", jd, 1'b1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped err", er, 1'b1);
        $display("test reset done");
    endtask : t_reset

    // One printed character: selects, register holds, position step.
    task t_print;
        @(posedge clk);
        avail <= 1'b1;
        @(posedge clk);
        avail <= 1'b0;
        wt(0);
        settle(1);
        chk("col", col, 16'h0020);
        chk("row", rsel, 8'h40);
        chk("half", {rhs, rhs_a}, 2'h1);
        chk("group print", grp, 5'h01);
        chk("dot first", dsel, 16'h0001);
        settle(1500);
        chk("col off", {memory_read_level, col}, 17'h0);
        chk("vert hold", vb, 4'hf);
        chk("horiz hold", hb, 3'h7);
        chk("dot second", dsel, 16'h0002);
        settle(600);
        chk("vert pass", vb, 4'h3);
        chk("horiz still", hb, 3'h7);
        chk("jd print", jd, 1'b0);
        settle(200);
        chk("horiz pass", hb, 3'h5);
        wt(2);
        settle(5);
        chk("lr step", lr, 1'b0);
        chk("pos pair", {pbl, pbl_n}, 2'h1);
        chk("pos upper", {pbm, pbm_n, pbh, pbh_n}, 4'h5);
        chk("group off", grp, 5'h00);
        chk("jd held", jd, 1'b1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("pos field", rd[6:0], 7'h01);
        $display("test print done");
    endtask : t_print

    // Jet-down hold off, then a carriage return homes the counter.
    task t_ctrl;
        apb(1'b1, ADDR_CTRL, 32'h0);
        settle(2);
        chk("jd free", jd, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl back", rd, 32'h0);
        @(posedge clk);
        cr <= 1'b1;
        @(posedge clk);
        cr <= 1'b0;
        settle(2);
        chk("cr home", lr, 1'b1);
        $display("test ctrl done");
    endtask : t_ctrl

    // Nonprint character cut short by a reset, then a paper advance run.
    task t_abort;
        @(posedge clk);
        np <= 1'b1;
        avail <= 1'b1;
        @(posedge clk);
        avail <= 1'b0;
        wt(0);
        settle(1);
        chk("np group", grp, 5'h00);
        chk("np row", rsel, 8'h40);
        @(posedge clk);
        srst <= 1'b1;
        np <= 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle(2);
        chk("cut row", {rsel, memory_read_level}, 9'h0);
        chk("cut jd", jd, 1'b1);
        @(posedge clk);
        pab <= 1'b1;
        settle(5);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("pa stat", rd, 32'h000e0000);
        chk("pa quiet", {grp, rsel, memory_read_level}, 14'h0);
        pab <= 1'b0;
        $display("test abort done");
    endtask : t_abort

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_print();
        t_ctrl();
        t_abort();
        test_done();
    end
endmodule : tb_top

// *** hdl/cpd_char_gen.sv ***
`timescale 1ns/1ps

module cpd_char_gen
    import cpd_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = DELAY_CYC,
    parameter int unsigned FRAME_CYCLES = FRAME_CYC,
    parameter int unsigned HHOLD_CYCLES = HHOLD_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CHAR_AVAIL,
    input wire logic [6:0] CHAR_CODE,
    input wire logic NONPRINT,
    input wire logic HTAB,
    input wire logic CR_REQ,
    input wire logic PAPER_ADV_BTN,
    input wire logic [6:0] DOT_DATA,
    output logic [4:0] GROUP_SEL,
    output logic LR_SEL,
    output logic POS_BIT_LOW,
    output logic POS_BIT_LOW_N,
    output logic POS_BIT_MID,
    output logic POS_BIT_MID_N,
    output logic POS_BIT_HIGH,
    output logic POS_BIT_HIGH_N,
    output logic ROW_HALF_SELECT,
    output logic ROW_HALF_SELECT_ALT,
    output logic MEMORY_READ_LEVEL,
    output logic [15:0] COL_SEL,
    output logic [7:0] ROW_SEL,
    output logic [15:0] DOT_SEL,
    output logic VERT_BIT_W1,
    output logic VERT_BIT_W2,
    output logic VERT_BIT_W4,
    output logic VERT_BIT_W8,
    output logic HORIZ_BIT_W1,
    output logic HORIZ_BIT_W2,
    output logic HORIZ_BIT_W4,
    output logic JET_DOWN
);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    // Sequencer state and its one-cycle start-of-cycle pulse.
    cpd_state_t state_q;
    logic soc_q;
    // Line position counter.
    logic [6:0] pos_q;
    // Buffered character and its latched qualifiers.
    logic [6:0] code_q;
    logic nonprint_q;
    logic htab_q;
    // Paper advance run flag.
    logic pa_q;
    // Control register and synchronisers for pin inputs.
    logic [2:0] ctrl_q;
    logic pa_s1_q, pa_s2_q, pa_s3_q;
    logic [6:0] dot_s1_q, dot_s2_q;
    // Memory output buffer and dot sequencer.
    logic [6:0] obuf_q;
    logic [3:0] dot_q;
    // Deflection registers and jet down.
    logic [3:0] vert_q;
    logic [2:0] horiz_q;
    logic jd_q;
    // Timing from the sub-blocks.
    logic frame_start, running, char_done;
    logic [4:0] frame_idx;
    logic delay_done, mp_busy, mp_done, vbusy, hbusy;
    // Derived controls.
    logic print_ivl, inhibit, pa_rise, pa_reach, step_en;
    logic [3:0] rate_bit;

    // Print interval: frames running for a real character.
    assign print_ivl = running && !pa_q;
    assign pa_rise = pa_s2_q && !pa_s3_q;
    assign inhibit = (nonprint_q && !htab_q) || pa_q;

    // The paper advance run ends when the chosen counter bit is set.
    always_comb begin
        case (ctrl_q[CTRL_RATE_LSB +: 2])
            RATE_16MS: rate_bit = 4'h1;
            RATE_32MS: rate_bit = 4'h2;
            RATE_64MS: rate_bit = 4'h3;
            default: rate_bit = 4'h1;
        endcase
    end
    assign pa_reach = pa_q && pos_q[rate_bit[2:0]];

    // Counter steps at character end; paper advance has its own path.
    // inhibit blocks step
    assign step_en = char_done && (pa_q || !inhibit);

    // The button is asynchronous; the dot lines come off-chip too.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pa_s1_q <= 1'b0;
            pa_s2_q <= 1'b0;
            pa_s3_q <= 1'b0;
            dot_s1_q <= '0;
            dot_s2_q <= '0;
        end else begin
            pa_s1_q <= PAPER_ADV_BTN;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            dot_s1_q <= DOT_DATA;
            dot_s2_q <= dot_s1_q;
        end
    end

    // Start delay of the character, a cycle count not a monostable.
    // clocked delay timer
    cpd_hold_timer #(.CYCLES(DELAY_CYCLES)) u_delay (
        .clk(CLK),
        .srst(SRST),
        .start(state_q == ST_IDLE && CHAR_AVAIL && !pa_q),
        .busy(),
        .done(delay_done)
    );

    cpd_frame_seq #(.FRAME_CYCLES(FRAME_CYCLES)) u_frames (
        .clk(CLK),
        .srst(SRST),
        .soc(soc_q),
        .frame_start(frame_start),
        .frame_idx(frame_idx),
        .running(running),
        .char_done(char_done)
    );

    // Memory read pulse and the two deflection hold windows, all started together by each frame start.
    cpd_hold_timer #(.CYCLES(MEMP_CYC)) u_memp (
        .clk(CLK),
        .srst(SRST),
        .start(frame_start),
        .busy(mp_busy),
        .done(mp_done)
    );

    cpd_hold_timer #(.CYCLES(VHOLD_CYC)) u_vhold (
        .clk(CLK),
        .srst(SRST),
        .start(frame_start),
        .busy(vbusy),
        .done()
    );

    cpd_hold_timer #(.CYCLES(HHOLD_CYCLES)) u_hhold (
        .clk(CLK),
        .srst(SRST),
        .start(frame_start),
        .busy(hbusy),
        .done()
    );

    // Sequencer: idle, start delay, then the print cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= ST_IDLE;
            soc_q <= 1'b0;
        end else begin
            soc_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // A paper advance run skips the start delay.
                    if (pa_q) begin
                        soc_q <= 1'b1;
                        state_q <= ST_PRINT;
                    end else if (CHAR_AVAIL) begin
                        state_q <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (delay_done) begin
                        soc_q <= 1'b1;
                        state_q <= ST_PRINT;
                    end
                end
                ST_PRINT: begin
                    if (char_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Input buffer is loaded at start of cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            code_q <= '0;
            nonprint_q <= 1'b0;
            htab_q <= 1'b0;
        end else if (state_q == ST_DELAY && delay_done) begin
            code_q <= CHAR_CODE;
            nonprint_q <= NONPRINT;
            htab_q <= HTAB;
        end
    end

    // Paper advance flag; a new press wins over the end of a run.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pa_q <= 1'b0;
        end else if (pa_rise) begin
            pa_q <= 1'b1;
        end else if (step_en && pa_reach) begin
            pa_q <= 1'b0;
        end
    end

    // Position counter; carriage return has priority over stepping.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pos_q <= POS_HOME;
        end else if (CR_REQ) begin
            pos_q <= POS_HOME;
        end else if (step_en) begin
            pos_q <= pa_reach ? POS_HOME : pos_q + 7'h01;
        end
    end

    // Spacing and left/right outputs follow the counter.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            GROUP_SEL <= '0;
            LR_SEL <= 1'b1;
            {POS_BIT_LOW, POS_BIT_MID, POS_BIT_HIGH} <= 3'h0;
            {POS_BIT_LOW_N, POS_BIT_MID_N, POS_BIT_HIGH_N} <= 3'h7;
        end else begin
            GROUP_SEL <= '0;
            if (print_ivl && !nonprint_q && !htab_q &&
                pos_q[6:GROUP_LSB] < 3'(NUM_GROUPS)) begin
                GROUP_SEL[pos_q[6:GROUP_LSB]] <= 1'b1;
            end
            LR_SEL <= !pos_q[0];
            POS_BIT_LOW <= pos_q[1];
            POS_BIT_LOW_N <= !pos_q[1];
            POS_BIT_MID <= pos_q[2];
            POS_BIT_MID_N <= !pos_q[2];
            POS_BIT_HIGH <= pos_q[3];
            POS_BIT_HIGH_N <= !pos_q[3];
        end
    end

    // Memory selection matrix.  Pairs use levels 7 and 5, since level
    // 6 is the complement of level 7 for every printing code.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            COL_SEL <= '0;
            ROW_SEL <= '0;
            MEMORY_READ_LEVEL <= 1'b0;
            ROW_HALF_SELECT <= 1'b0;
            ROW_HALF_SELECT_ALT <= 1'b1;
        end else begin
            COL_SEL <= '0;
            ROW_SEL <= '0;
            MEMORY_READ_LEVEL <= mp_busy && print_ivl;
            ROW_HALF_SELECT <= frame_idx[HALF_BIT];
            ROW_HALF_SELECT_ALT <= !frame_idx[HALF_BIT];
            if (print_ivl) begin
                ROW_SEL[{code_q[6], code_q[4], frame_idx[HALF_BIT]}] <= 1'b1;
                if (mp_busy) begin
                    COL_SEL[code_q[3:0]] <= 1'b1;
                end
            end
        end
    end

    // Dot sequencer steps after each memory pulse; the output buffer
    // captures the parallel dot word at the same moment.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            dot_q <= '0;
            obuf_q <= '0;
        end else if (soc_q) begin
            dot_q <= '0;
        end else if (mp_done) begin
            dot_q <= dot_q + 4'h1;
            obuf_q <= dot_s2_q;
        end
    end

    // One-hot dot select, one line per dot.
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_dot
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    DOT_SEL[g] <= 1'b0;
                end else begin
                    DOT_SEL[g] <= print_ivl && (dot_q == 4'(g));
                end
            end
        end
    endgenerate

    // Deflection registers hold through their windows, then follow
    // the inverted buffer so a late dot word cannot smear the trace.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            vert_q <= '0;
            horiz_q <= '0;
        end else begin
            if (!vbusy) begin
                vert_q <= ~obuf_q[3:0];
            end
            if (!hbusy) begin
                horiz_q <= ~obuf_q[6:4];
            end
        end
    end

    // Jet down: all vertical bits high outside the hold marks a blank.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            jd_q <= 1'b1;
        end else if (print_ivl) begin
            jd_q <= (&vert_q) && !vbusy;
        end else begin
            jd_q <= ctrl_q[CTRL_JDHOLD_BIT] || (&vert_q);
        end
    end

    assign {VERT_BIT_W8, VERT_BIT_W4, VERT_BIT_W2, VERT_BIT_W1} = vert_q;
    assign {HORIZ_BIT_W4, HORIZ_BIT_W2, HORIZ_BIT_W1} = horiz_q;
    assign JET_DOWN = jd_q;

    // APB slave: one wait state, unmapped addresses answer an error.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY &&
                       PADDR != ADDR_CTRL && PADDR != ADDR_STAT;
            PRDATA <= '0;
            if (PSEL && PENABLE && !PREADY && !PWRITE) begin
                if (PADDR == ADDR_CTRL) begin
                    PRDATA <= {29'h0, ctrl_q};
                end else if (PADDR == ADDR_STAT) begin
                    PRDATA <= {12'h0, pa_q, running, 2'(state_q),
                               3'h0, frame_idx, 1'b0, pos_q};
                end
            end
        end
    end

    // Control register write, taken in the completing access cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= CTRL_RESET;
        end else if (PSEL && PENABLE && PREADY && PWRITE &&
                     PADDR == ADDR_CTRL) begin
            ctrl_q <= PWDATA[2:0];
        end
    end

    // The buffer reloads at the end of the pulse, so a hold that
    // leaked would show there and not at the start of the frame.
    sequence s_pulse_hold;
        mp_done ##1 vbusy;
    endsequence

    a_group_onehot: assert property ($onehot0(GROUP_SEL))
        else $error("group select not one-hot");
    a_group_delay: assert property (
        state_q == ST_DELAY |=> GROUP_SEL == 5'h00)
        else $error("group active during start delay");
    a_lr_invert: assert property (
        1'b1 |=> LR_SEL == !$past(pos_q[0]))
        else $error("left/right not inverted lowest bit");
    a_pos_pairs: assert property (
        POS_BIT_LOW != POS_BIT_LOW_N && POS_BIT_HIGH != POS_BIT_HIGH_N &&
        POS_BIT_MID != POS_BIT_MID_N)
        else $error("position pair not complementary");
    a_inhibit_stop: assert property (
        char_done && inhibit && !pa_q && !CR_REQ |=> $stable(pos_q))
        else $error("counter stepped under inhibit");
    a_pa_step: assert property (
        char_done && pa_q && !pa_reach && !CR_REQ
        |=> pos_q == $past(pos_q) + 7'h01)
        else $error("paper advance did not step counter");
    a_col_pulse: assert property (
        |COL_SEL |-> MEMORY_READ_LEVEL && $onehot(COL_SEL))
        else $error("column select outside memory pulse");
    a_vert_hold: assert property (
        s_pulse_hold |=> $stable(vert_q) [*8])
        else $error("vertical register moved during hold");
    a_cr_home: assert property (CR_REQ |=> pos_q == POS_HOME)
        else $error("carriage return did not home counter");
    a_jd_idle: assert property (
        !print_ivl && ctrl_q[CTRL_JDHOLD_BIT] |=> JET_DOWN)
        else $error("jet down not held while idle");

endmodule : cpd_char_gen

// *** hdl/cpd_frame_seq.sv ***
`timescale 1ns/1ps

// Frame oscillator: start of cycle begins frame 0, the timer the rest.
module cpd_frame_seq
    import cpd_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic soc,
    output logic frame_start,
    output logic [4:0] frame_idx,
    output logic running,
    output logic char_done
);

    localparam int W = $clog2(FRAME_CYCLES + 1);
    localparam logic [W-1:0] RELOAD = W'(FRAME_CYCLES - 1);
    localparam logic [W-1:0] ONE = W'(1);

    // Cycles left in the current frame.
    logic [W-1:0] tcnt_q;
    // High at the last cycle of a frame while running.
    logic frame_end;

    assign frame_end = running && (tcnt_q == '0);

    // Frame timer and frame index.
    always_ff @(posedge clk) begin
        if (srst) begin
            tcnt_q <= '0;
            frame_idx <= '0;
            running <= 1'b0;
        end else if (soc) begin
            tcnt_q <= RELOAD;
            frame_idx <= '0;
            running <= 1'b1;
        end else if (frame_end) begin
            tcnt_q <= RELOAD;
            frame_idx <= frame_idx + 5'h01;
            // The oscillator stops itself after the last frame.
            running <= (frame_idx != LAST_FRAME);
        end else if (running) begin
            tcnt_q <= tcnt_q - ONE;
        end
    end

    // Frame start and end-of-character pulses, one cycle each.
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_start <= 1'b0;
            char_done <= 1'b0;
        end else begin
            frame_start <= soc || (frame_end && frame_idx != LAST_FRAME);
            char_done <= frame_end && (frame_idx == LAST_FRAME);
        end
    end

endmodule : cpd_frame_seq

// *** hdl/cpd_hold_timer.sv ***
`timescale 1ns/1ps

// Retriggerable one-shot that replaces a monostable network.
module cpd_hold_timer
    import cpd_pkg::*;
#(
    parameter int unsigned CYCLES = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    output logic busy,
    output logic done
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    localparam logic [W-1:0] ONE = W'(1);

    // Remaining cycles of the hold; zero means idle.
    logic [W-1:0] cnt_q;

    // A new start reloads the count, so a retrigger extends the hold.
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - ONE;
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == ONE);

endmodule : cpd_hold_timer

// *** hdl/cpd_pkg.sv ***
package cpd_pkg;

    // Clock period of the system clock in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    // One timing frame, the time given to one dot.
    localparam int FRAME_NS = 250000;
    // Width of one memory read pulse.
    localparam int MEMP_NS = 10000;
    // Time the vertical register holds after a memory pulse.
    localparam int VHOLD_NS = 20000;
    // Time the horizontal register holds after a memory pulse.
    localparam int HHOLD_NS = 200000;
    // Delay between character arrival and start of cycle.
    localparam int DELAY_NS = 4000000;

    // Cycle counts; these are least times, so they round up.
    localparam int FRAME_CYC = (FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEMP_CYC = (MEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VHOLD_CYC = (VHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HHOLD_CYC = (HHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_CYC = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frames per character interval and the index of the last one.
    localparam int FRAMES_PER_CHAR = 32;
    localparam logic [4:0] LAST_FRAME = 5'h1f;
    // Frame index bit that picks the half of the character cycle.
    localparam int HALF_BIT = 4;
    // Number of groups on a line and the lowest position field bits.
    localparam int NUM_GROUPS = 5;
    localparam int GROUP_LSB = 4;
    localparam logic [6:0] POS_HOME = 7'h00;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    // Control register fields and reset value.
    localparam int CTRL_JDHOLD_BIT = 0;
    localparam int CTRL_RATE_LSB = 1;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // Paper advance rate codes: the counter bit that ends a run.
    localparam logic [1:0] RATE_16MS = 2'h0;
    localparam logic [1:0] RATE_32MS = 2'h1;
    localparam logic [1:0] RATE_64MS = 2'h2;

    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PRINT} cpd_state_t;

endpackage : cpd_pkg
